//--- rtl/tpc_trace_port.sv
`timescale 1ns/1ps
module tpc_trace_port
   import tpc_pkg::*;
#(
   parameter int TRC_W = TRACE_WIDTH,
   parameter int DEPTH = FIFO_DEPTH
)(
   // system clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst,
   // trace port clock
   input  wire logic             tracePortClk,
   // trace word input, rise half in low bits
   input  wire logic             wordValid,
   input  wire logic [2*TRC_W-1:0] wordData,
   output logic                  wordReady,
   // control and status, system domain
   input  wire logic             traceEnable,
   input  wire logic             formatMode,
   input  wire logic             triggerReq,
   output logic                  triggerBusy,
   output logic                  triggerDone,
   // pad side, rise and fall halves both registered on the rising clock edge
   output logic [TRC_W-1:0]      traceDataBusRise,
   output logic                  traceControlLineRise,
   output logic [TRC_W-1:0]      traceDataBusFall,
   output logic                  traceControlLineFall,
   output logic                  formatFlag
);

   localparam int PW = 2 * TRC_W;
   localparam logic [FRAME_CNT_W-1:0] BYTES_PER_PERIOD =
      FRAME_CNT_W'(PW / BYTE_BITS);

   // ************************************************************
   // declarations
   // ************************************************************
   logic                 rstLinkMeta_q, rstLink_q;
   logic                 reqTgl_q, reqTgl_d;
   logic                 ackSync, ackSeen_q, ackSeen_d;
   logic                 busy_q, busy_d, done_q, done_d;
   logic                 wrReady_q;
   logic [2:0]           linkLevels;
   logic                 enLink, fmtLink, reqLink;
   tpc_state_t           state_q, state_d;
   logic                 seenTgl_q, seenTgl_d;
   logic [FRAME_CNT_W-1:0] frameCnt_q, frameCnt_d;
   logic                 trigPend, atBoundary, doTrig, doPop;
   tpc_half_t            riseKind, fallKind;
   logic [TRC_W:0]       riseOut_q, riseOut_d, fallOut_q, fallOut_d;
   logic                 fmtOut_q;

   tpc_stream_if #(.WIDTH(PW)) wrIf ();
   tpc_stream_if #(.WIDTH(PW)) rdIf ();

   // builds control and data for one half period
   function automatic logic [TRC_W:0] encodeHalf(input tpc_half_t kind,
                                                 input logic [TRC_W-1:0] data);
      logic [TRC_W-1:0] low;
      low = '0;
      case (kind)
         HALF_DATA:    encodeHalf = {CTL_NORMAL, data};
         HALF_TRIGGER:
         begin
            low[1:0]   = LOW2_TRIGGER;
            encodeHalf = {CTL_SPECIAL, low};
         end
         default:
         begin
            low[1:0]   = LOW2_DISABLE;
            encodeHalf = {CTL_SPECIAL, low};
         end
      endcase
   endfunction

   // ************************************************************
   // link reset, async assert, released on link clock
   // ************************************************************
   always_ff @(posedge tracePortClk or posedge rst)
   begin
      if (rst)
      begin
         rstLinkMeta_q <= 1'h1;
         rstLink_q     <= 1'h1;
      end
      else
      begin
         rstLinkMeta_q <= 1'h0;
         rstLink_q     <= rstLinkMeta_q;
      end
   end

   // ************************************************************
   // data buffer across domains
   // ************************************************************
   assign wrIf.valid = wordValid;
   assign wrIf.data  = wordData;

   // trace clock unrelated to system clock
   tpc_async_fifo #(.WIDTH(PW), .DEPTH(DEPTH)) uFifo (
      .wrClk (clk_sys),
      .wrRst (rst),
      .wr    (wrIf),
      .rdClk (tracePortClk),
      .rdRst (rstLink_q),
      .rd    (rdIf)
   );

   assign rdIf.ready = doPop;

   // ************************************************************
   // system side trigger handshake
   // ************************************************************
   tpc_sync #(.WIDTH(1)) uAckSync (
      .clk  (clk_sys),
      .rst  (rst),
      .din  (seenTgl_q),
      .dout (ackSync)
   );

   always_comb
   begin
      reqTgl_d  = reqTgl_q;
      busy_d    = busy_q;
      ackSeen_d = ackSync;
      done_d    = (ackSync != ackSeen_q);
      if (done_d)
      begin
         busy_d = 1'h0;
      end
      if (triggerReq && !busy_q)
      begin
         reqTgl_d = ~reqTgl_q;
         busy_d   = 1'h1;
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         reqTgl_q  <= 1'h0;
         ackSeen_q <= 1'h0;
         busy_q    <= 1'h0;
         done_q    <= 1'h0;
         wrReady_q <= 1'h0;
      end
      else
      begin
         reqTgl_q  <= reqTgl_d;
         ackSeen_q <= ackSeen_d;
         busy_q    <= busy_d;
         done_q    <= done_d;
         wrReady_q <= wrIf.ready;
      end
   end

   // ************************************************************
   // levels into the link domain
   // ************************************************************
   tpc_sync #(.WIDTH(3)) uLinkSync (
      .clk  (tracePortClk),
      .rst  (rstLink_q),
      .din  ({reqTgl_q, formatMode, traceEnable}),
      .dout (linkLevels)
   );

   assign enLink  = linkLevels[0];
   assign fmtLink = linkLevels[1];
   assign reqLink = linkLevels[2];

   // ************************************************************
   // link side sequencing
   // ************************************************************
   always_comb
   begin
      trigPend   = (reqLink != seenTgl_q);
      // frames stay whole in formatted mode
      atBoundary = !fmtLink || (frameCnt_q == '0);
      doTrig     = (state_q == ST_STREAM) && trigPend && atBoundary;
      doPop      = (state_q == ST_STREAM) && rdIf.valid && !doTrig;
      seenTgl_d  = doTrig ? reqLink : seenTgl_q;
      frameCnt_d = frameCnt_q;
      if (!fmtLink)
      begin
         frameCnt_d = '0;
      end
      else if (doPop)
      begin
         frameCnt_d = frameCnt_q + BYTES_PER_PERIOD;
      end
      state_d = state_q;
      case (state_q)
         ST_IDLE:
         begin
            if (enLink)
            begin
               state_d = ST_STREAM;
            end
         end
         ST_STREAM:
         begin
            if (!enLink && (!fmtLink || frameCnt_d == '0))
            begin
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   // ************************************************************
   // pin values for both edges
   // ************************************************************
   always_comb
   begin
      riseKind = HALF_DISABLE;
      fallKind = HALF_DISABLE;
      if (doTrig)
      begin
         // trigger in rising half, no data
         riseKind = HALF_TRIGGER;
      end
      else if (doPop)
      begin
         // two trace cycles per clock period
         riseKind = HALF_DATA;
         fallKind = HALF_DATA;
      end
      riseOut_d = encodeHalf(riseKind, rdIf.data[TRC_W-1:0]);
      fallOut_d = encodeHalf(fallKind, rdIf.data[PW-1:TRC_W]);
   end

   always_ff @(posedge tracePortClk or posedge rstLink_q)
   begin
      if (rstLink_q)
      begin
         state_q    <= ST_IDLE;
         seenTgl_q  <= 1'h0;
         frameCnt_q <= '0;
         riseOut_q  <= {CTL_SPECIAL, (TRC_W-2)'(0), LOW2_DISABLE};
         fallOut_q  <= {CTL_SPECIAL, (TRC_W-2)'(0), LOW2_DISABLE};
         fmtOut_q   <= 1'h0;
      end
      else
      begin
         state_q    <= state_d;
         seenTgl_q  <= seenTgl_d;
         frameCnt_q <= frameCnt_d;
         riseOut_q  <= riseOut_d;
         fallOut_q  <= fallOut_d;
         fmtOut_q   <= fmtLink;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign wordReady            = wrReady_q;
   assign triggerBusy          = busy_q;
   assign triggerDone          = done_q;
   assign traceControlLineRise = riseOut_q[TRC_W];
   assign traceDataBusRise     = riseOut_q[TRC_W-1:0];
   assign traceControlLineFall = fallOut_q[TRC_W];
   assign traceDataBusFall     = fallOut_q[TRC_W-1:0];
   // tells the decoder which content is in use
   assign formatFlag           = fmtOut_q;

endmodule // tpc_trace_port

//--- rtl/tpc_pkg.sv
package tpc_pkg;

   // ************************************************************
   // pin encodings
   // ************************************************************
   localparam logic       CTL_NORMAL     = 1'h0;
   localparam logic       CTL_SPECIAL    = 1'h1;
   localparam logic [1:0] LOW2_TRIG_PKT  = 2'h0;
   localparam logic [1:0] LOW2_TRIGGER   = 2'h2;
   localparam logic [1:0] LOW2_DISABLE   = 2'h1;

   // ************************************************************
   // sizes
   // ************************************************************
   localparam int         TRACE_WIDTH    = 8;
   localparam int         FIFO_DEPTH     = 32;
   localparam int         SYNC_STAGES    = 2;
   localparam int         FRAME_BYTES    = 16;
   localparam int         FRAME_CNT_W    = 4;
   localparam int         BYTE_BITS      = 8;

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [1:0] {HALF_DATA, HALF_TRIGGER, HALF_DISABLE} tpc_half_t;
   typedef enum logic       {ST_IDLE, ST_STREAM} tpc_state_t;

endpackage

//--- rtl/tpc_stream_if.sv
`timescale 1ns/1ps
interface tpc_stream_if #(parameter int WIDTH = 16);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

//--- rtl/tpc_sync.sv
`timescale 1ns/1ps
module tpc_sync
   import tpc_pkg::*;
#(
   parameter int WIDTH = 1
)(
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // levels
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // ************************************************************
   // two flops per bit
   // ************************************************************
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         meta_q <= din;
         sync_q <= meta_q;
      end
   end

   assign dout = sync_q;

endmodule // tpc_sync

//--- rtl/tpc_async_fifo.sv
`timescale 1ns/1ps
module tpc_async_fifo
   import tpc_pkg::*;
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = FIFO_DEPTH
)(
   // write side
   input  wire logic wrClk,
   input  wire logic wrRst,
   tpc_stream_if.snk wr,
   // read side
   input  wire logic rdClk,
   input  wire logic rdRst,
   tpc_stream_if.src rd
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wBin_q, wBin_d, wGray_q, wGray_d;
   logic [AW:0]      rBin_q, rBin_d, rGray_q, rGray_d;
   logic [AW:0]      rGraySync, wGraySync;
   logic             full_q, full_d, empty_q, empty_d;
   logic             doWr, doRd;

   function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
      bin2gray = b ^ (b >> 1);
   endfunction

   // ************************************************************
   // pointer crossings
   // ************************************************************
   tpc_sync #(.WIDTH(AW+1)) uRdToWr (
      .clk  (wrClk),
      .rst  (wrRst),
      .din  (rGray_q),
      .dout (rGraySync)
   );

   tpc_sync #(.WIDTH(AW+1)) uWrToRd (
      .clk  (rdClk),
      .rst  (rdRst),
      .din  (wGray_q),
      .dout (wGraySync)
   );

   // ************************************************************
   // write side
   // ************************************************************
   assign doWr     = wr.valid && !full_q;
   assign wr.ready = !full_q;

   always_comb
   begin
      wBin_d  = wBin_q + (AW+1)'(doWr);
      wGray_d = bin2gray(wBin_d);
      full_d  = (wGray_d == {~rGraySync[AW:AW-1], rGraySync[AW-2:0]});
   end

   always_ff @(posedge wrClk or posedge wrRst)
   begin
      if (wrRst)
      begin
         wBin_q  <= '0;
         wGray_q <= '0;
         full_q  <= 1'h0;
      end
      else
      begin
         wBin_q  <= wBin_d;
         wGray_q <= wGray_d;
         full_q  <= full_d;
      end
   end

   always_ff @(posedge wrClk)
   begin
      if (doWr)
      begin
         mem[wBin_q[AW-1:0]] <= wr.data;
      end
   end

   // ************************************************************
   // read side
   // ************************************************************
   assign doRd     = rd.ready && !empty_q;
   assign rd.valid = !empty_q;
   assign rd.data  = mem[rBin_q[AW-1:0]];

   always_comb
   begin
      rBin_d  = rBin_q + (AW+1)'(doRd);
      rGray_d = bin2gray(rBin_d);
      empty_d = (rGray_d == wGraySync);
   end

   always_ff @(posedge rdClk or posedge rdRst)
   begin
      if (rdRst)
      begin
         rBin_q  <= '0;
         rGray_q <= '0;
         empty_q <= 1'h1;
      end
      else
      begin
         rBin_q  <= rBin_d;
         rGray_q <= rGray_d;
         empty_q <= empty_d;
      end
   end

endmodule // tpc_async_fifo

//--- sim/tpc_trace_port_chk.sv
`timescale 1ns/1ps
module tpc_trace_port_chk
   import tpc_pkg::*;
#(
   parameter int TRC_W = TRACE_WIDTH
)(
   // system side
   input wire logic             clk_sys,
   input wire logic             rst,
   input wire logic             triggerReq,
   input wire logic             triggerBusy,
   input wire logic             triggerDone,
   // link side
   input wire logic             tracePortClk,
   input wire logic [TRC_W-1:0] traceDataBusRise,
   input wire logic             traceControlLineRise,
   input wire logic [TRC_W-1:0] traceDataBusFall,
   input wire logic             traceControlLineFall
);
   // **********
   // properties
   // **********
   sequence sTake;
      triggerReq && !triggerBusy;
   endsequence
   sequence sTrig;
      traceControlLineRise && traceDataBusRise[1:0] == LOW2_TRIGGER;
   endsequence

   chk_req_busy:
   assert property (@(posedge clk_sys) disable iff (rst) sTake |=> triggerBusy)
      else $error("busy missing after request");
   chk_done_pulse:
   assert property (@(posedge clk_sys) disable iff (rst) triggerDone |=> !triggerDone)
      else $error("done longer than one cycle");
   chk_done_release:
   assert property (@(posedge clk_sys) disable iff (rst)
      triggerDone |-> !triggerBusy && $past(triggerBusy))
      else $error("busy not released by done");
   chk_busy_hold:
   assert property (@(posedge clk_sys) disable iff (rst)
      $fell(triggerBusy) |-> triggerDone)
      else $error("busy dropped early");
   chk_done_bound:
   assert property (@(posedge clk_sys) disable iff (rst)
      $rose(triggerBusy) |-> ##[2:1000] triggerDone)
      else $error("trigger never completed");
   chk_trig_fall:
   assert property (@(posedge tracePortClk) disable iff (rst)
      sTrig |-> traceControlLineFall && traceDataBusFall[0])
      else $error("half after trigger not disable");
   chk_trig_empty:
   assert property (@(posedge tracePortClk) disable iff (rst)
      sTrig |-> traceDataBusRise[TRC_W-1:2] == '0)
      else $error("trigger carries data");
   chk_no_pkt:
   assert property (@(posedge tracePortClk) disable iff (rst)
      !(traceControlLineFall && traceDataBusFall[1:0] == LOW2_TRIG_PKT))
      else $error("packet code on fall half");
endmodule // tpc_trace_port_chk

bind tpc_trace_port tpc_trace_port_chk #(.TRC_W(TRC_W)) u_chk (
   .clk_sys(clk_sys), .rst(rst), .triggerReq(triggerReq),
   .triggerBusy(triggerBusy), .triggerDone(triggerDone), .tracePortClk(tracePortClk),
   .traceDataBusRise(traceDataBusRise), .traceControlLineRise(traceControlLineRise),
   .traceDataBusFall(traceDataBusFall), .traceControlLineFall(traceControlLineFall)
);

//--- sim/tpc_capture_model.sv
`timescale 1ns/1ps
module tpc_capture_model
   import tpc_pkg::*;
#(
   parameter int TRC_W    = TRACE_WIDTH,
   parameter int POST_TRG = 8
)(
   // trace port
   input wire logic             tracePortClk,
   input wire logic [TRC_W-1:0] riseData,
   input wire logic             riseCtl,
   input wire logic [TRC_W-1:0] fallData,
   input wire logic             fallCtl
);
   // **********
   // decoder
   // **********
   logic [TRC_W-1:0] stored[$];
   int               trigCount = 0;
   int               trigAt    = -1;
   int               postLeft  = -1;

   task automatic decode(input logic c, input logic [TRC_W-1:0] d);
      if (postLeft > 0)
         postLeft--;
      if (postLeft == 0)
         return;
      if (c === CTL_NORMAL)
         stored.push_back(d);
      else if (d[0] !== 1'b0)
         return;
      else
      begin
         trigCount++;
         trigAt   = stored.size();
         postLeft = POST_TRG;
         if (d[1] === 1'b0)
            stored.push_back(d);
      end
   endtask

   always @(negedge tracePortClk)
   begin
      decode(riseCtl, riseData);
      decode(fallCtl, fallData);
   end
endmodule // tpc_capture_model

//--- sim/test_trace_port_capture_decode.sv
`timescale 1ns/1ps
module test_trace_port_capture_decode
   import tpc_pkg::*;
;
   typedef struct {logic [15:0] w; logic [7:0] r; logic [7:0] f;} tpc_row_t;
   tpc_row_t rows[8] = '{'{16'h0300, 8'h00, 8'h03}, '{16'h0102, 8'h02, 8'h01},
      '{16'hFD01, 8'h01, 8'hFD}, '{16'h00FF, 8'hFF, 8'h00}, '{16'hA5C2, 8'hC2, 8'hA5},
      '{16'h7E3F, 8'h3F, 8'h7E}, '{16'h8080, 8'h80, 8'h80}, '{16'h0001, 8'h01, 8'h00}};
   logic        clk_sys      = 1'b0;
   logic        tracePortClk = 1'b0;
   logic        rst          = 1'b1;
   logic        wordValid    = 1'b0;
   logic [15:0] wordData     = 16'h0000;
   logic        traceEnable  = 1'b0;
   logic        formatMode   = 1'b0;
   logic        triggerReq   = 1'b0;
   logic        wordReady, triggerBusy, triggerDone, rCtl, fCtl, formatFlag;
   logic [7:0]  rData, fData;
   int          bad_count = 0;
   int          checks    = 0;
   int          cycles    = 0;
   int          n;

   // **********
   // clocks and parts
   // **********
   always #2.5 clk_sys = ~clk_sys;
   initial
   begin
      #1.3;
      forever #7.5 tracePortClk = ~tracePortClk;
   end

   tpc_trace_port u_tpc_trace_port (.clk_sys(clk_sys), .rst(rst),
      .tracePortClk(tracePortClk), .wordValid(wordValid), .wordData(wordData),
      .wordReady(wordReady), .traceEnable(traceEnable), .formatMode(formatMode),
      .triggerReq(triggerReq), .triggerBusy(triggerBusy), .triggerDone(triggerDone),
      .traceDataBusRise(rData), .traceControlLineRise(rCtl), .traceDataBusFall(fData),
      .traceControlLineFall(fCtl), .formatFlag(formatFlag));
   tpc_capture_model u_tpc_capture_model (.tracePortClk(tracePortClk), .riseData(rData),
      .riseCtl(rCtl), .fallData(fData), .fallCtl(fCtl));

   // **********
   // tasks
   // **********
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input logic ok, input string msg);
      checks++;
      if (ok !== 1'b1)
      begin
         bad_count++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask
   task automatic chkIdle;
      check(!wordReady && !triggerBusy && !triggerDone && !formatFlag, "sys reset");
      check(rCtl && rData === 8'h01 && fCtl && fData === 8'h01, "link reset");
   endtask
   task automatic push(input logic [15:0] w);
      int k;
      k = 0;
      while (wordReady !== 1'b1 && k < 400)
      begin
         @(negedge clk_sys);
         k++;
      end
      wordValid = 1'b1;
      wordData  = w;
      @(negedge clk_sys);
      wordValid = 1'b0;
      repeat (2) @(negedge clk_sys);
   endtask
   task automatic waitStored(input int k);
      int t;
      t = 0;
      while (u_tpc_capture_model.stored.size() < k && t < 2000)
      begin
         @(negedge clk_sys);
         t++;
      end
   endtask
   task automatic pulseTrig;
      triggerReq = 1'b1;
      @(negedge clk_sys);
      triggerReq = 1'b0;
      @(negedge clk_sys);
   endtask

   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         bad_count++;
         final_report();
      end
   end

   // **********
   // sequence
   // **********
   initial
   begin
      repeat (10) @(negedge clk_sys);
      chkIdle();
      rst = 1'b0;
      n   = 0;
      while ((n == 0 || wordReady === 1'b1) && n < 40)
      begin
         push(rows[n % 8].w);
         n++;
      end
      check(n == FIFO_DEPTH, "buffer refused at wrong count");
      traceEnable = 1'b1;
      waitStored(64);
      for (int i = 0; i < 32; i++)
         check(u_tpc_capture_model.stored[2*i] === rows[i%8].r &&
            u_tpc_capture_model.stored[2*i+1] === rows[i%8].f, "stored data");
      check(u_tpc_capture_model.trigCount == 0, "normal data seen as trigger");
      formatMode = 1'b1;
      n = 0;
      while (formatFlag !== 1'b1 && n < 100)
      begin
         @(negedge clk_sys);
         n++;
      end
      check(formatFlag === 1'b1, "format flag");
      u_tpc_capture_model.stored.delete();
      for (int i = 0; i < 3; i++)
         push(rows[i].w);
      waitStored(6);
      pulseTrig();
      pulseTrig();
      for (int i = 3; i < 8; i++)
         push(rows[i].w);
      n = 0;
      while (triggerDone !== 1'b1 && n < 2000)
      begin
         @(negedge clk_sys);
         n++;
      end
      check(u_tpc_capture_model.trigAt == 2 * FRAME_BYTES / 2, "trigger mid frame");
      check(u_tpc_capture_model.trigCount == 1, "trigger count");
      repeat (20) @(negedge clk_sys);
      push(rows[0].w);
      repeat (60) @(negedge clk_sys);
      check(u_tpc_capture_model.stored.size() == 16, "capture after trigger");
      rst = 1'b1;
      repeat (10) @(negedge clk_sys);
      chkIdle();
      rst = 1'b0;
      repeat (4) @(negedge clk_sys);
      check(wordReady === 1'b1 && rCtl === 1'b1 && rData === 8'h01, "after reset");
      final_report();
   end
endmodule // test_trace_port_capture_decode
